// ---- mcsr_master.sv ----
// Serial master model at the far side of the register bank's link.
// Assumes a 64 ns link clock; the clock rests low between frames, high only while polling.
`timescale 1ns/1ps
module mcsr_master (
	output logic      SCK,
	output logic      SDI,
	output logic      STROBE_N,
	input  wire logic SDO,
	input  wire logic SDO_OE
);
	logic last_sdo;
	logic sdo_line;
	initial begin
		SCK = 1'b0;
		SDI = 1'b0;
		STROBE_N = 1'b1;
		last_sdo = 1'b0;
	end
	always @(SDO or SDO_OE) if (SDO_OE) last_sdo = SDO;
	// No pull on the pin, so a released line shows the opposite of its last bit
	assign sdo_line = SDO_OE ? SDO : ~last_sdo;
	task automatic xfer(input logic [15:0] word, input int edges, output logic [15:0] rx);
		rx = 16'h0000;
		if (edges == 0) SCK = 1'b1;
		#32 STROBE_N = 1'b0;
		for (int i = 0; i < edges; i++) begin
			SDI = (i < 16) ? word[15 - i] : 1'b0;
			#32 rx = {rx[14:0], sdo_line};
			SCK = 1'b1;
			#32 SCK = 1'b0;
		end
		#64 if (edges == 0) rx = {15'h0000, sdo_line};
		STROBE_N = 1'b1;
		SDI = ~SDI;
		#32 SCK = 1'b0;
		#64;
	endtask : xfer
endmodule : mcsr_master

// ---- mcsr_pkg.sv ----
// Constants for the serial configuration and diagnostic register bank.
// Assumes a 250 MHz system clock and 16-bit serial words, most significant bit first.
package mcsr_pkg;
	// ****************************************
	// Word layout
	// ****************************************
	localparam int          WORD_BITS     = 16;
	localparam int          ADDR_MSB      = 15;
	localparam int          ADDR_LSB      = 13;
	localparam int          WR_BIT        = 12;
	localparam logic [4:0]  EDGES_FULL    = 5'd16;
	localparam logic [4:0]  EDGES_OVER    = 5'd17;
	localparam logic [4:0]  EDGES_WR      = 5'd3;
	localparam logic [4:0]  DIAG_HEAD     = 5'd3;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [2:0]  TIMING_CONFIG  = 3'h0;
	localparam logic [2:0]  VOLTAGE_CONFIG = 3'h1;
	localparam logic [2:0]  PWM_CONFIG     = 3'h2;
	localparam logic [2:0]  HOLD_CONFIG    = 3'h3;
	localparam logic [2:0]  START_CONFIG   = 3'h4;
	localparam logic [2:0]  SPEED_CONFIG   = 3'h5;
	localparam logic [2:0]  FAULT_MASK     = 3'h6;
	localparam logic [2:0]  RUN_CONTROL    = 3'h7;

	// ****************************************
	// Reset values (low twelve bits)
	// ****************************************
	localparam logic [11:0] TIMING_RST  = 12'h214;
	localparam logic [11:0] VOLTAGE_RST = 12'h3df;
	localparam logic [11:0] PWM_RST     = 12'h793;
	localparam logic [11:0] HOLD_RST    = 12'h752;
	localparam logic [11:0] START_RST   = 12'h773;
	localparam logic [11:0] SPEED_RST   = 12'h778;
	localparam logic [11:0] MASK_RST    = 12'h000;
	localparam logic [11:0] RUN_RST     = 12'h009;

	// ****************************************
	// Diagnostic layout
	// ****************************************
	localparam int          DIAG_ANY      = 15;
	localparam int          DIAG_POR      = 14;
	localparam int          DIAG_SERR     = 13;
	localparam logic [11:0] DIAG_FAULTS   = 12'hebf;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int RECIRC_LSB = 10;
	localparam int BLANK_LSB  = 6;
	localparam int DEAD_LSB   = 0;
	localparam int DECAY_BIT  = 11;
	localparam int INVERT_BIT = 10;
	localparam int ILIM_LSB   = 6;
	localparam int VDSQ_BIT   = 5;
	localparam int VDST_LSB   = 0;
	localparam int GAIN_LSB   = 8;
	localparam int OVSP_LSB   = 6;
	localparam int DEGAUSS_BIT = 5;
	localparam int OFFT_LSB   = 0;
	localparam int DUTY_LSB   = 4;
	localparam int LOW4_LSB   = 0;
	localparam int VOUT_BIT   = 7;
	localparam int MAXV_LSB   = 4;
	localparam int CTRL_LSB   = 10;
	localparam int SHORT_BIT  = 9;
	localparam int DEMAND_LSB = 4;
	localparam int RESYNC_BIT = 3;
	localparam int BRAKE_BIT  = 2;
	localparam int DIR_BIT    = 1;
	localparam int RUN_BIT    = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          BLANK_STEP_NS = 400;
	localparam int          DEAD_STEP_NS  = 50;
	localparam logic [5:0]  DEAD_MIN_CODE = 6'h02;
endpackage : mcsr_pkg

// ---- mcsr_regs.sv ----
// Serial register bank: link slave, eight writeable registers, latched diagnostics, timers.
// Assumes fault inputs come from logic on REF_CLK; serial pins are asynchronous.
//
// What this block does
// - Sixteen-bit words, msb first; top three bits pick one of eight registers.
// - Write with store bit set shifts out the diagnostic word.
// - Two-bit recirculation select: auto, high, low, off.
// - Blanking lasts blank field times 400 ns, counted on the system clock.
// - Dead time is field times 50 ns; codes 0 to 2 give 100 ns.
// - Reset loads blank 1000 and dead 010100.
// - Fast-decay select chooses 12.5 or 25 percent, resets to zero.
// - PWM input invert bit flips the PWM input sense, default off.
// - Register 1 holds current limit code and drain monitor qualifier select.
// - Five-bit drain-source threshold in 50 mV steps.
// - Register 2 holds angle gain, overspeed ratio, degauss enable.
// - Five-bit off time or period field in register 2.
// - Register 3 holds angle integral gain and hold duty.
// - Four-bit hold time in 8 ms steps from zero.
// - Register 4 holds velocity gain and start duty.
// - Four-bit start speed field, 2 Hz steps from 2 Hz.
// - Register 5 holds velocity integral gain, output select, max velocity code.
// - Four-bit phase advance in 1.875 degree steps.
// - Masked diagnostics never set a flag or bit.
// - Run register holds mode, stop-on-short, demand, restart, brake, direction, run.
// - On sync loss restart if enabled, running and not braking; coast only if restart is disabled.
// - Fault flags latch; cleared only on completed access; live faults stay set.
// - Reset sets any-fault and power-on flags, clears the rest, reloads registers.
// - Strobe fall drives output with any-fault flag; strobe rise releases it.
// - Bit 12 is store enable; zero reads back the addressed register.
// - Wrong edge count cancels write, keeps diagnostics, sets error flags.
// - Input sampled on clock rise with strobe low; output moves on fall.
`timescale 1ns/1ps
module mcsr_regs
	import mcsr_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        SCK,
	input  wire logic        SDI,
	input  wire logic        STROBE_N,
	output logic             SDO,
	output logic             SDO_OE,
	input  wire logic [11:0] FAULT_IN,
	input  wire logic        PWM_IN,
	output logic             PWM_TRUE,
	input  wire logic        BLANK_START,
	output logic             BLANK_ACTIVE,
	input  wire logic        DEAD_START,
	output logic             DEAD_ACTIVE,
	input  wire logic        SYNC_LOST,
	output logic             RESTART_REQ,
	output logic             COAST_STOP,
	output logic [1:0]       RECIRC_SELECT,
	output logic [3:0]       BLANK_TIME,
	output logic [5:0]       DEAD_TIME,
	output logic             FAST_DECAY_PCT,
	output logic             PWM_INPUT_INVERT,
	output logic [3:0]       CURRENT_LIMIT_REF,
	output logic             VDS_QUALIFIER_SELECT,
	output logic [4:0]       DRAIN_SOURCE_THRESHOLD,
	output logic [3:0]       ANGLE_PROP_GAIN,
	output logic [1:0]       OVERSPEED_RATIO,
	output logic             DEGAUSS_COMP_ENABLE,
	output logic [4:0]       OFF_TIME_PERIOD,
	output logic [3:0]       ANGLE_INTEG_GAIN,
	output logic [3:0]       HOLD_DUTY,
	output logic [3:0]       HOLD_TIME,
	output logic [3:0]       VELOCITY_PROP_GAIN,
	output logic [3:0]       START_DUTY,
	output logic [3:0]       START_SPEED,
	output logic [3:0]       VELOCITY_INTEG_GAIN,
	output logic             VELOCITY_OUTPUT_SELECT,
	output logic [2:0]       MAX_VELOCITY_CODE,
	output logic [3:0]       PHASE_ADVANCE,
	output logic [1:0]       CONTROL_SELECT,
	output logic             STOP_ON_SHORT,
	output logic [4:0]       SERIAL_DEMAND,
	output logic             RESYNC_RESTART,
	output logic             BRAKE_ENABLE,
	output logic             DIRECTION,
	output logic             RUN_ENABLE,
	output logic [15:0]      DIAG_STATUS
);
	import mcsr_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	// Least times round up to whole cycles
	function automatic logic [10:0] ns_to_cycles(input logic [15:0] ns);
		logic [15:0] c;
		c = (ns + 16'(CLK_PERIOD_NS - 1)) / 16'(CLK_PERIOD_NS);
		return c[10:0];
	endfunction : ns_to_cycles

	// ****************************************
	// Storage
	// ****************************************
	logic [11:0] cfg [0:7];
	logic [11:0] diag_faults;
	logic        diag_por;
	logic        diag_serr;
	logic [15:0] diag_word;
	logic [11:0] fault_live;

	function automatic logic [11:0] read_reg(input logic [2:0] a);
		return cfg[a];
	endfunction : read_reg

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sck_sync;
	logic [2:0] sdi_sync;
	logic [2:0] strb_sync;
	logic [1:0] pwm_sync;

	always_ff @(posedge REF_CLK) begin
		sck_sync  <= {sck_sync[1:0], SCK};
		sdi_sync  <= {sdi_sync[1:0], SDI};
		strb_sync <= {strb_sync[1:0], STROBE_N};
		pwm_sync  <= {pwm_sync[0], PWM_IN};
	end

	logic sck_rise;
	logic sck_fall;
	logic strb_fall;
	logic strb_rise;
	logic strb_low;

	assign strb_low  = ~strb_sync[1];
	assign strb_fall = ~strb_sync[1] & strb_sync[2];
	assign strb_rise = strb_sync[1] & ~strb_sync[2];
	assign sck_rise  = sck_sync[1] & ~sck_sync[2] & strb_low;
	assign sck_fall  = ~sck_sync[1] & sck_sync[2] & strb_low;

	// ****************************************
	// Serial receive
	// ****************************************
	logic [15:0] rx_shift;
	logic [4:0]  edge_cnt;
	logic [4:0]  out_idx;
	logic [15:0] tx_diag;
	logic [11:0] tx_word;
	logic        xfer_ok;
	logic        xfer_err;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rx_shift <= 16'h0000;
			edge_cnt <= 5'd0;
		end else if (strb_fall) begin
			edge_cnt <= 5'd0;
		end else if (sck_rise) begin
			rx_shift <= {rx_shift[14:0], sdi_sync[1]};
			if (edge_cnt != EDGES_OVER) begin
				edge_cnt <= edge_cnt + 5'd1;
			end
		end
	end

	// Zero edges is a flag poll, not an error
	assign xfer_ok  = strb_rise & (edge_cnt == EDGES_FULL);
	assign xfer_err = strb_rise & (edge_cnt != EDGES_FULL) & (edge_cnt != 5'd0);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cfg[TIMING_CONFIG]  <= TIMING_RST;
			cfg[VOLTAGE_CONFIG] <= VOLTAGE_RST;
			cfg[PWM_CONFIG]     <= PWM_RST;
			cfg[HOLD_CONFIG]    <= HOLD_RST;
			cfg[START_CONFIG]   <= START_RST;
			cfg[SPEED_CONFIG]   <= SPEED_RST;
			cfg[FAULT_MASK]     <= MASK_RST;
			cfg[RUN_CONTROL]    <= RUN_RST;
		end else if (xfer_ok && rx_shift[WR_BIT]) begin
			cfg[rx_shift[ADDR_MSB:ADDR_LSB]] <= rx_shift[11:0];
		end
	end

	// ****************************************
	// Diagnostics
	// ****************************************
	assign fault_live = FAULT_IN & ~cfg[FAULT_MASK] & DIAG_FAULTS;

	// Live faults win over the clear so nothing present is lost
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			diag_faults <= 12'h000;
			diag_por    <= 1'b1;
			diag_serr   <= 1'b0;
		end else begin
			diag_faults <= fault_live | (xfer_ok ? 12'h000 : diag_faults);
			if (xfer_ok) begin
				diag_por <= 1'b0;
			end
			if (xfer_err) begin
				diag_serr <= 1'b1;
			end else if (xfer_ok) begin
				diag_serr <= 1'b0;
			end
		end
	end

	// Bit 12 has no flag behind it and always reads zero
	always_comb begin
		diag_word            = 16'h0000;
		diag_word[11:0]      = diag_faults;
		diag_word[DIAG_SERR] = diag_serr;
		diag_word[DIAG_POR]  = diag_por;
		diag_word[DIAG_ANY]  = diag_por | diag_serr | (|diag_faults);
	end
	assign DIAG_STATUS = diag_word;

	// ****************************************
	// Serial transmit
	// ****************************************
	// Bit 12 goes out before the store bit arrives, so it reads as zero
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			tx_diag <= 16'h0000;
			tx_word <= 12'h000;
			out_idx <= 5'd0;
		end else if (strb_fall) begin
			tx_diag <= diag_word;
			out_idx <= 5'd0;
		end else begin
			if (sck_fall && out_idx != EDGES_FULL) begin
				out_idx <= out_idx + 5'd1;
			end
			if (sck_rise && edge_cnt == EDGES_WR) begin
				tx_word <= sdi_sync[1] ? tx_diag[11:0]
				                       : read_reg(rx_shift[2:0]);
			end
		end
	end

	logic next_sdo;
	logic [3:0] bit_pos;

	always_comb begin
		bit_pos  = 4'(15 - 32'(out_idx));
		next_sdo = 1'b0;
		if (out_idx < DIAG_HEAD) begin
			next_sdo = tx_diag[bit_pos];
		end else if (out_idx < EDGES_FULL && out_idx != DIAG_HEAD) begin
			next_sdo = tx_word[bit_pos];
		end
		if (strb_fall) begin
			next_sdo = diag_word[DIAG_ANY];
		end
	end

	// ****************************************
	// Output pins
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SDO    <= 1'b0;
			SDO_OE <= 1'b0;
		end else begin
			SDO    <= strb_low ? next_sdo : 1'b0;
			SDO_OE <= strb_low;
		end
	end

	// ****************************************
	// Blank and dead timers
	// ****************************************
	logic [10:0] blank_cnt;
	logic [10:0] dead_cnt;
	logic [5:0]  dead_code;

	// Codes below the floor clamp to the shortest dead time
	assign dead_code = (DEAD_TIME < DEAD_MIN_CODE) ? DEAD_MIN_CODE : DEAD_TIME;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			blank_cnt <= 11'd0;
		end else if (BLANK_START) begin
			blank_cnt <= ns_to_cycles(16'(BLANK_TIME) * 16'(BLANK_STEP_NS));
		end else if (blank_cnt != 11'd0) begin
			blank_cnt <= blank_cnt - 11'd1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			dead_cnt <= 11'd0;
		end else if (DEAD_START) begin
			dead_cnt <= ns_to_cycles(16'(dead_code) * 16'(DEAD_STEP_NS));
		end else if (dead_cnt != 11'd0) begin
			dead_cnt <= dead_cnt - 11'd1;
		end
	end

	assign BLANK_ACTIVE = (blank_cnt != 11'd0);
	assign DEAD_ACTIVE  = (dead_cnt != 11'd0);

	// ****************************************
	// PWM sense and resync
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			PWM_TRUE    <= 1'b0;
			RESTART_REQ <= 1'b0;
			COAST_STOP  <= 1'b0;
		end else begin
			PWM_TRUE    <= pwm_sync[1] ^ PWM_INPUT_INVERT;
			RESTART_REQ <= SYNC_LOST & RESYNC_RESTART & RUN_ENABLE & ~BRAKE_ENABLE;
			COAST_STOP  <= SYNC_LOST & ~RESYNC_RESTART;
		end
	end

	// ****************************************
	// Timing fields
	// ****************************************
	assign RECIRC_SELECT          = cfg[TIMING_CONFIG][RECIRC_LSB +: 2];
	assign BLANK_TIME             = cfg[TIMING_CONFIG][BLANK_LSB +: 4];
	assign DEAD_TIME              = cfg[TIMING_CONFIG][DEAD_LSB +: 6];

	// ****************************************
	// Voltage fields
	// ****************************************
	assign FAST_DECAY_PCT         = cfg[VOLTAGE_CONFIG][DECAY_BIT];
	assign PWM_INPUT_INVERT       = cfg[VOLTAGE_CONFIG][INVERT_BIT];
	assign CURRENT_LIMIT_REF      = cfg[VOLTAGE_CONFIG][ILIM_LSB +: 4];
	assign VDS_QUALIFIER_SELECT   = cfg[VOLTAGE_CONFIG][VDSQ_BIT];
	assign DRAIN_SOURCE_THRESHOLD = cfg[VOLTAGE_CONFIG][VDST_LSB +: 5];

	// ****************************************
	// PWM fields
	// ****************************************
	assign ANGLE_PROP_GAIN        = cfg[PWM_CONFIG][GAIN_LSB +: 4];
	assign OVERSPEED_RATIO        = cfg[PWM_CONFIG][OVSP_LSB +: 2];
	assign DEGAUSS_COMP_ENABLE    = cfg[PWM_CONFIG][DEGAUSS_BIT];
	assign OFF_TIME_PERIOD        = cfg[PWM_CONFIG][OFFT_LSB +: 5];

	// ****************************************
	// Hold fields
	// ****************************************
	assign ANGLE_INTEG_GAIN       = cfg[HOLD_CONFIG][GAIN_LSB +: 4];
	assign HOLD_DUTY              = cfg[HOLD_CONFIG][DUTY_LSB +: 4];
	assign HOLD_TIME              = cfg[HOLD_CONFIG][LOW4_LSB +: 4];

	// ****************************************
	// Start fields
	// ****************************************
	assign VELOCITY_PROP_GAIN     = cfg[START_CONFIG][GAIN_LSB +: 4];
	assign START_DUTY             = cfg[START_CONFIG][DUTY_LSB +: 4];
	assign START_SPEED            = cfg[START_CONFIG][LOW4_LSB +: 4];

	// ****************************************
	// Speed fields
	// ****************************************
	assign VELOCITY_INTEG_GAIN    = cfg[SPEED_CONFIG][GAIN_LSB +: 4];
	assign VELOCITY_OUTPUT_SELECT = cfg[SPEED_CONFIG][VOUT_BIT];
	assign MAX_VELOCITY_CODE      = cfg[SPEED_CONFIG][MAXV_LSB +: 3];
	assign PHASE_ADVANCE          = cfg[SPEED_CONFIG][LOW4_LSB +: 4];

	// ****************************************
	// Run fields
	// ****************************************
	assign CONTROL_SELECT         = cfg[RUN_CONTROL][CTRL_LSB +: 2];
	assign STOP_ON_SHORT          = cfg[RUN_CONTROL][SHORT_BIT];
	assign SERIAL_DEMAND          = cfg[RUN_CONTROL][DEMAND_LSB +: 5];
	assign RESYNC_RESTART         = cfg[RUN_CONTROL][RESYNC_BIT];
	assign BRAKE_ENABLE           = cfg[RUN_CONTROL][BRAKE_BIT];
	assign DIRECTION              = cfg[RUN_CONTROL][DIR_BIT];
	assign RUN_ENABLE             = cfg[RUN_CONTROL][RUN_BIT];
endmodule : mcsr_regs

// ---- mcsr_regs_checker.sv ----
// Port-level assertions for the serial register bank, bound to its top module.
// Assumes the bench never masks fault input 11 and never retriggers a running timer.
`timescale 1ns/1ps
module mcsr_regs_checker (
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	input wire logic        STROBE_N,
	input wire logic        SDO,
	input wire logic        SDO_OE,
	input wire logic [11:0] FAULT_IN,
	input wire logic        PWM_IN,
	input wire logic        PWM_TRUE,
	input wire logic        PWM_INPUT_INVERT,
	input wire logic        BLANK_START,
	input wire logic        BLANK_ACTIVE,
	input wire logic [3:0]  BLANK_TIME,
	input wire logic        DEAD_START,
	input wire logic        DEAD_ACTIVE,
	input wire logic [5:0]  DEAD_TIME,
	input wire logic        SYNC_LOST,
	input wire logic        RESYNC_RESTART,
	input wire logic        RUN_ENABLE,
	input wire logic        BRAKE_ENABLE,
	input wire logic        RESTART_REQ,
	input wire logic        COAST_STOP,
	input wire logic [15:0] DIAG_STATUS
);
	import mcsr_pkg::*;
	// ****************
	// Helper counters
	// ****************
	logic [15:0] idle_cnt;
	logic [15:0] blank_cnt;
	logic [15:0] dead_cnt;
	logic [5:0]  dead_eff;
	// Codes under the floor all give the shortest dead time
	assign dead_eff = (DEAD_TIME < DEAD_MIN_CODE) ? DEAD_MIN_CODE : DEAD_TIME;
	always_ff @(posedge REF_CLK) begin
		idle_cnt <= (SYS_RST || !STROBE_N) ? 16'h0000 : idle_cnt + 16'h0001;
	end
	always_ff @(posedge REF_CLK) begin
		blank_cnt <= BLANK_START ? 16'h0000 : blank_cnt + {15'h0000, BLANK_ACTIVE};
	end
	always_ff @(posedge REF_CLK) begin
		dead_cnt <= DEAD_START ? 16'h0000 : dead_cnt + {15'h0000, DEAD_ACTIVE};
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// ****************
	// Assertions
	// ****************
	reset_word_a: assert property ($fell(SYS_RST) |-> DIAG_STATUS == 16'hc000 && !SDO_OE)
		else $error("diagnostic word or enable wrong after reset");
	live_fault_a: assert property (FAULT_IN[11] |=> DIAG_STATUS[11] && DIAG_STATUS[15])
		else $error("live fault not shown");
	latch_hold_a: assert property (DIAG_STATUS[0] && idle_cnt > 16'h0008 |=> DIAG_STATUS[0])
		else $error("latched fault lost without a transfer");
	any_fault_a: assert property (DIAG_STATUS[11:0] != 12'h000 |-> DIAG_STATUS[15])
		else $error("any-fault flag low with a fault bit set");
	oe_on_a: assert property ($fell(STROBE_N) |-> ##[1:6] SDO_OE)
		else $error("output not driven after strobe fall");
	oe_off_a: assert property ($rose(STROBE_N) |-> ##[1:6] !SDO_OE)
		else $error("output not released after strobe rise");
	first_bit_a: assert property ($rose(SDO_OE) |-> SDO == $past(DIAG_STATUS[15]))
		else $error("first output bit is not the any-fault flag");
	blank_len_a: assert property ($fell(BLANK_ACTIVE) |-> blank_cnt == {12'h000, BLANK_TIME} * 16'h0064)
		else $error("blanking length wrong");
	dead_len_a: assert property ($fell(DEAD_ACTIVE) |-> dead_cnt == ({10'h000, dead_eff} * 16'h0032 + 16'h0003) / 16'h0004)
		else $error("dead time length wrong");
	restart_a: assert property (SYNC_LOST && RESYNC_RESTART && RUN_ENABLE && !BRAKE_ENABLE |=> RESTART_REQ && !COAST_STOP)
		else $error("no restart after sync loss");
	coast_a: assert property (SYNC_LOST && !RESYNC_RESTART |=> COAST_STOP && !RESTART_REQ)
		else $error("no coast after sync loss");
	pwm_sense_a: assert property (($stable(PWM_IN) && $stable(PWM_INPUT_INVERT)) [*5] |-> PWM_TRUE == (PWM_IN ^ PWM_INPUT_INVERT))
		else $error("pwm sense wrong");
endmodule : mcsr_regs_checker
bind mcsr_regs mcsr_regs_checker chk (.REF_CLK, .SYS_RST, .STROBE_N, .SDO, .SDO_OE, .FAULT_IN, .PWM_IN, .PWM_TRUE,
	.PWM_INPUT_INVERT, .BLANK_START, .BLANK_ACTIVE, .BLANK_TIME, .DEAD_START, .DEAD_ACTIVE, .DEAD_TIME, .SYNC_LOST,
	.RESYNC_RESTART, .RUN_ENABLE, .BRAKE_ENABLE, .RESTART_REQ, .COAST_STOP, .DIAG_STATUS);

// ---- mcsr_regs_dummy_guard.sv ----
// Holds no logic; the whole register bank sits in mcsr_regs.sv.
// Assumes nothing of its surroundings.

// ---- mcsr_regs_test.sv ----
// Self-checking bench for the serial register bank, driven through the serial master model.
// Assumes package constants hold the reset values and the field layout of each register.
`timescale 1ns/1ps
module mcsr_regs_test;
	import mcsr_pkg::*;
	logic REF_CLK, SYS_RST, SCK, SDI, STROBE_N, SDO, SDO_OE, PWM_IN, PWM_TRUE, BLANK_START, BLANK_ACTIVE;
	logic DEAD_START, DEAD_ACTIVE, SYNC_LOST, RESTART_REQ, COAST_STOP, FAST_DECAY_PCT, PWM_INPUT_INVERT;
	logic VDS_QUALIFIER_SELECT, DEGAUSS_COMP_ENABLE, VELOCITY_OUTPUT_SELECT, STOP_ON_SHORT, RESYNC_RESTART;
	logic BRAKE_ENABLE, DIRECTION, RUN_ENABLE;
	logic [1:0]  RECIRC_SELECT, OVERSPEED_RATIO, CONTROL_SELECT;
	logic [2:0]  MAX_VELOCITY_CODE;
	logic [3:0]  BLANK_TIME, CURRENT_LIMIT_REF, ANGLE_PROP_GAIN, ANGLE_INTEG_GAIN, HOLD_DUTY, HOLD_TIME;
	logic [3:0]  VELOCITY_PROP_GAIN, START_DUTY, START_SPEED, VELOCITY_INTEG_GAIN, PHASE_ADVANCE;
	logic [4:0]  DRAIN_SOURCE_THRESHOLD, OFF_TIME_PERIOD, SERIAL_DEMAND;
	logic [5:0]  DEAD_TIME;
	logic [11:0] FAULT_IN;
	logic [15:0] DIAG_STATUS, rx;
	logic [11:0] rst_val [8] = '{TIMING_RST, VOLTAGE_RST, PWM_RST, HOLD_RST, START_RST, SPEED_RST, MASK_RST, RUN_RST};
	int fail_count = 0;
	int comparisons = 0;
	mcsr_regs dut (.*);
	mcsr_master m (.*);
	always #2 REF_CLK = ~REF_CLK;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [11:0] fields(input logic [2:0] a);
		case (a)
			3'h0: return {RECIRC_SELECT, BLANK_TIME, DEAD_TIME};
			3'h1: return {FAST_DECAY_PCT, PWM_INPUT_INVERT, CURRENT_LIMIT_REF, VDS_QUALIFIER_SELECT, DRAIN_SOURCE_THRESHOLD};
			3'h2: return {ANGLE_PROP_GAIN, OVERSPEED_RATIO, DEGAUSS_COMP_ENABLE, OFF_TIME_PERIOD};
			3'h3: return {ANGLE_INTEG_GAIN, HOLD_DUTY, HOLD_TIME};
			3'h4: return {VELOCITY_PROP_GAIN, START_DUTY, START_SPEED};
			3'h5: return {VELOCITY_INTEG_GAIN, VELOCITY_OUTPUT_SELECT, MAX_VELOCITY_CODE, PHASE_ADVANCE};
			3'h7: return {CONTROL_SELECT, STOP_ON_SHORT, SERIAL_DEMAND, RESYNC_RESTART, BRAKE_ENABLE, DIRECTION, RUN_ENABLE};
			default: return 12'h000;
		endcase
	endfunction : fields
	task automatic send(input logic [15:0] w, input int n);
		m.xfer(w, n, rx);
		@(negedge REF_CLK);
	endtask : send
	task automatic run_timer(input logic blank, output int n);
		n = 0;
		if (blank) BLANK_START = 1'b1;
		else DEAD_START = 1'b1;
		// Long enough for the largest code of either timer
		repeat (1700) begin
			@(negedge REF_CLK);
			BLANK_START = 1'b0;
			DEAD_START = 1'b0;
			n += blank ? int'(BLANK_ACTIVE) : int'(DEAD_ACTIVE);
		end
	endtask : run_timer
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset_read();
		chk("diag after reset", 16'hc000, DIAG_STATUS);
		for (int a = 0; a < 8; a++) begin
			send({3'(a), 1'b0, 12'hfff}, 16);
			chk("readback", {((a == 0) ? 3'b110 : 3'b000), 1'b0, rst_val[a]}, rx);
			if (a != 6) chk("reset fields", {4'h0, rst_val[a]}, {4'h0, fields(3'(a))});
		end
	endtask : t_reset_read
	task automatic t_write_all();
		logic [11:0] p;
		for (int a = 0; a < 8; a++) begin
			p = 12'h5a3 ^ {4{3'(a)}};
			if (a == 6) continue;
			send({3'(a), 1'b1, p}, 16);
			chk("write answer", 16'h0000, rx);
			chk("fields", {4'h0, p}, {4'h0, fields(3'(a))});
			send({3'(a), 1'b0, 12'h000}, 16);
			chk("readback", {4'h0, p}, rx);
		end
	endtask : t_write_all
	task automatic t_timers();
		logic [3:0] bt [4] = '{4'hf, 4'h1, 4'h0, 4'h8};
		logic [5:0] dt [4] = '{6'h01, 6'h3f, 6'h02, 6'h00};
		int n;
		int e;
		for (int i = 0; i < 4; i++) begin
			send({TIMING_CONFIG, 1'b1, 2'(i), bt[i], dt[i]}, 16);
			chk("recirc", 16'(i), {14'h0000, RECIRC_SELECT});
			run_timer(1'b1, n);
			chk("blank", 16'(bt[i] * (BLANK_STEP_NS / CLK_PERIOD_NS)), 16'(n));
			run_timer(1'b0, n);
			e = ((dt[i] < DEAD_MIN_CODE ? DEAD_MIN_CODE : dt[i]) * DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
			chk("dead", 16'(e), 16'(n));
		end
	endtask : t_timers
	task automatic t_refuse();
		int cnt [2] = '{15, 17};
		for (int i = 0; i < 2; i++) begin
			FAULT_IN = 12'h011;
			@(negedge REF_CLK);
			FAULT_IN = 12'h000;
			send({TIMING_CONFIG, 1'b1, 12'h0ff}, cnt[i]);
			chk("refused diag", 16'ha011, DIAG_STATUS);
			send({TIMING_CONFIG, 1'b0, 12'h000}, 16);
			chk("no write", 16'hae00, rx);
			chk("diag cleared", 16'h0000, DIAG_STATUS);
		end
	endtask : t_refuse
	task automatic t_poll_mask();
		send({FAULT_MASK, 1'b1, 12'h001}, 16);
		FAULT_IN = 12'h801;
		@(negedge REF_CLK);
		send(16'h0000, 0);
		chk("poll flag", 16'h0001, rx);
		chk("masked diag", 16'h8800, DIAG_STATUS);
		send({FAULT_MASK, 1'b1, 12'h000}, 16);
		chk("diag answer", 16'h8800, rx);
		chk("live kept", 16'h8801, DIAG_STATUS);
		FAULT_IN = 12'h000;
		@(negedge REF_CLK);
		send({FAULT_MASK, 1'b0, 12'h000}, 16);
		chk("mask readback", 16'h8000, rx);
		chk("diag clear", 16'h0000, DIAG_STATUS);
	endtask : t_poll_mask
	task automatic t_pwm_resync();
		logic [11:0] rv [3] = '{12'h001, 12'h009, 12'h00d};
		PWM_IN = 1'b1;
		send({VOLTAGE_CONFIG, 1'b1, 12'h400}, 16);
		chk("pwm inverted", 16'h0000, {15'h0000, PWM_TRUE});
		send({VOLTAGE_CONFIG, 1'b1, 12'h000}, 16);
		chk("pwm true", 16'h0001, {15'h0000, PWM_TRUE});
		for (int i = 0; i < 3; i++) begin
			send({RUN_CONTROL, 1'b1, rv[i]}, 16);
			SYNC_LOST = 1'b1;
			@(negedge REF_CLK);
			SYNC_LOST = 1'b0;
			chk("restart", 16'(i == 1), {15'h0000, RESTART_REQ});
			chk("coast", 16'(i == 0), {15'h0000, COAST_STOP});
		end
	endtask : t_pwm_resync
	initial begin
		REF_CLK = 1'b0;
		SYS_RST = 1'b1;
		FAULT_IN = 12'h000;
		PWM_IN = 1'b0;
		BLANK_START = 1'b0;
		DEAD_START = 1'b0;
		SYNC_LOST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		t_reset_read();
		t_write_all();
		t_timers();
		t_refuse();
		t_poll_mask();
		t_pwm_resync();
		finish_test();
	end
	initial begin
		#300000;
		fail_count++;
		finish_test();
	end
endmodule : mcsr_regs_test
